// ### hdl/acc_map.svh
/*
  named constants for the conversion controller pair: timing, pin slots
  of the shared result bus, host register offsets and bit positions.
  assumes a 125 MHz hclk shared by both ends.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// clock and timing
`define ACC_CLK_NS     8
`define ACC_ACQ_NS     1500
`define ACC_ACQ_CYC    ((`ACC_ACQ_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_BIT_NS     400
`define ACC_BIT_CYC    (`ACC_BIT_NS / `ACC_CLK_NS)
`define ACC_SCLK_HALF  8
`define ACC_START_LOW  4
// parallel capture wait: must outlast both pin synchronisers and the
// converter's registered upper pins, or the first word is read stale
`define ACC_READ_HOLD  12
`define ACC_RES_BITS   16
`define ACC_MSB        15

// shared pins in serial mode
`define ACC_PIN_SERIAL_RESULT_OUT  8
`define ACC_PIN_SCLK   9
`define ACC_PIN_SYNC   10
`define ACC_PIN_RDERR  11

// synchroniser reset: reset 0, start/select/read 1, rest 0
`define ACC_PIN_RST    11'h380

// host registers
`define ACC_REG_CTRL   5'h00
`define ACC_REG_STATUS 5'h04
`define ACC_REG_RESULT 5'h08
`define ACC_REG_ISTAT  5'h0c
`define ACC_REG_IMASK  5'h10

// control bits
`define ACC_CB_START   0
`define ACC_CB_PD      1
`define ACC_CB_REFOFF  2
`define ACC_CB_BUFOFF  3
`define ACC_CB_SERIAL  4
`define ACC_CB_CODING  5
`define ACC_CB_CLKSRC  6
`define ACC_CB_RESET   7

// interrupt bits
`define ACC_IB_READY   0
`define ACC_IB_RDERR   1

`endif

// ### hdl/acc_pkg.sv
/*
  types shared by both ends of the conversion controller.
  assumes acc_map.svh supplies the numeric constants.
*/
package acc_pkg;

  // converter sequencing states
  typedef enum logic [3:0] {
    DS_ACQ   = 4'b0001,
    DS_ARM   = 4'b0010,
    DS_CONV  = 4'b0100,
    DS_SLEEP = 4'b1000
  } acc_dev_state_e;

  // controller sequencing states
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_WAIT  = 4'b0100,
    HS_READ  = 4'b1000
  } acc_host_state_e;

  // pins seen by the converter, in synchroniser order
  typedef struct packed {
    logic reset;
    logic cnv_n;
    logic cs_n;
    logic rd_n;
    logic pd;
    logic ref_off;
    logic buf_off;
    logic iface;
    logic coding;
    logic clksrc;
    logic sclk;
  } acc_pins_s;

endpackage

// ### hdl/acc_if.sv
/*
  pin-level link between the converter and its controller.
  assumes no clock of its own; the shared bus level is resolved here.
*/
`timescale 1ns/10ps
`include "acc_map.svh"

interface acc_if;
  logic        conversion_start_n;   // start strobe, active low
  logic        cs_n;                 // chip select
  logic        rd_n;                 // read strobe
  logic        reset;                // converter reset, active high
  logic        power_down;           // stop after current conversion
  logic        internal_ref_off;     // on-chip reference off
  logic        ref_buffer_off;       // reference buffer off
  logic        interface_select;     // 0 parallel, 1 serial
  logic        output_coding_select; // 1 straight binary, 0 twos complement
  logic        clock_source_select;  // 0 converter clocks, 1 controller clocks
  logic        busy;                 // conversion running
  logic [11:0] dev_lo_o;             // shared pins, converter drive
  logic [11:0] dev_lo_oe;            // shared pins, converter enable
  logic [3:0]  dev_hi_o;             // upper result pins, always outputs
  logic        host_sclk_o;          // serial clock from controller
  logic        host_sclk_oe;         // controller drives serial clock
  logic [15:0] d_bus;                // resolved pin level

  // undriven pins read low
  assign d_bus = {dev_hi_o, dev_lo_o & dev_lo_oe}
               | (16'(host_sclk_o & host_sclk_oe) << `ACC_PIN_SCLK);

  modport dev (
    input  conversion_start_n, cs_n, rd_n, reset, power_down, internal_ref_off,
           ref_buffer_off, interface_select, output_coding_select,
           clock_source_select, d_bus,
    output busy, dev_lo_o, dev_lo_oe, dev_hi_o
  );

  modport host (
    output conversion_start_n, cs_n, rd_n, reset, power_down, internal_ref_off,
           ref_buffer_off, interface_select, output_coding_select,
           clock_source_select, host_sclk_o, host_sclk_oe,
    input  busy, d_bus
  );
endinterface

// ### hdl/acc_dev.sv
/*
  converter end: start handling, conversion timing on the internal clock,
  result latch, parallel and serial result output, static reference pins.
  assumes the controller drives the link pins; all pins are resynchronised.
*/
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "acc_map.svh"

module acc_dev import acc_pkg::*; (
  input  wire logic        hclk,          // converter clock
  input  wire logic        hresetn,       // async reset, active low
  acc_if.dev               link,          // pins to the controller
  input  wire logic [15:0] sample_value,  // analog level, as a code
  output logic             sample_hold,   // sampler in hold
  output logic             low_power,     // reduced-power operation
  output logic             ref_powered,   // on-chip reference on
  output logic             ref_buffer_on, // reference buffer on
  output logic [15:0]      last_result    // latched result
);

  // output coding: straight binary or twos complement
  function automatic logic [15:0] acc_code(input logic [15:0] v, input logic binary);
    acc_code = v ^ {~binary, 15'h0000};
  endfunction

  acc_pins_s       s1_q, s2_q, s3_q, pin_q; // pin synchroniser stages
  acc_pins_s       pin_raw;                 // pins as they arrive
  acc_dev_state_e  state_q, state_d;        // sequencing state
  logic [7:0]      cnt_q;                   // acquisition / bit timer
  logic [3:0]      bit_q;                   // bit under decision
  logic [15:0]     held_q;                  // held sample
  logic [15:0]     sar_q;                   // decided bits
  logic [15:0]     result_q;                // coded result
  logic [15:0]     shift_q;                 // serial shift register
  logic [4:0]      left_q;                  // bits still to shift
  logic            cnv_prev_q;              // start strobe last cycle
  logic            sclk_prev_q;             // external clock last cycle
  logic            int_sclk_q;              // internal serial clock
  logic [3:0]      div_q;                   // serial clock divider
  logic            rderr_q;                 // read error pulse
  logic            read_act_q;              // slave read under way
  logic [11:0]     lo_q;                    // registered shared-pin data
  logic [3:0]      hi_q;                    // registered upper pins
  logic            rd_en;                   // bus enable
  logic            acq_end, bit_end, conv_done, cnv_fall, sclk_fall, half_tick;
  logic            serial, ext_clk;

  assign pin_raw = '{reset: link.reset, cnv_n: link.conversion_start_n, cs_n: link.cs_n,
                     rd_n: link.rd_n, pd: link.power_down, ref_off: link.internal_ref_off,
                     buf_off: link.ref_buffer_off, iface: link.interface_select,
                     coding: link.output_coding_select, clksrc: link.clock_source_select,
                     sclk: link.d_bus[`ACC_PIN_SCLK]};

  // three-stage synchroniser; a bit moves once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= `ACC_PIN_RST;
      s2_q  <= `ACC_PIN_RST;
      s3_q  <= `ACC_PIN_RST;
      pin_q <= `ACC_PIN_RST;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
    end
  end

  assign rd_en     = ~pin_q.cs_n & ~pin_q.rd_n;
  assign serial    = pin_q.iface;
  assign ext_clk   = pin_q.clksrc;
  assign cnv_fall  = cnv_prev_q & ~pin_q.cnv_n;
  assign sclk_fall = sclk_prev_q & ~pin_q.sclk & ~pin_q.cs_n;
  assign acq_end   = (state_q == DS_ACQ) && (cnt_q == 8'(`ACC_ACQ_CYC - 1));
  assign bit_end   = (state_q == DS_CONV) && (cnt_q == 8'(`ACC_BIT_CYC - 1));
  assign conv_done = bit_end && (bit_q == 4'(`ACC_MSB)) && !pin_q.reset;
  assign half_tick = (div_q == 4'(`ACC_SCLK_HALF - 1));

  // next sequencing state
  always_comb begin
    state_d = state_q;
    case (state_q)
      DS_ACQ: begin
        if (acq_end) begin
          if (pin_q.pd) state_d = DS_SLEEP;
          else if (!pin_q.cnv_n) state_d = DS_CONV;
          else state_d = DS_ARM;
        end
      end
      DS_ARM: begin
        if (pin_q.pd) state_d = DS_SLEEP;
        else if (cnv_fall) state_d = DS_CONV;
      end
      DS_CONV: begin
        // a running conversion finishes despite power down; only the reset pin aborts it
        if (bit_end && bit_q == 4'(`ACC_MSB)) state_d = pin_q.pd ? DS_SLEEP : DS_ACQ;
      end
      DS_SLEEP: begin
        if (!pin_q.pd) state_d = DS_ACQ;
      end
      default: state_d = DS_ACQ;
    endcase
  end

  // state, timer and bit counter; reset pin aborts everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= DS_ACQ;
      cnt_q      <= 8'h00;
      bit_q      <= 4'h0;
      cnv_prev_q <= 1'b1;
    end else if (pin_q.reset) begin
      state_q    <= DS_ACQ;
      cnt_q      <= 8'h00;
      bit_q      <= 4'h0;
      cnv_prev_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnv_prev_q <= pin_q.cnv_n;
      if (state_d != state_q) cnt_q <= 8'h00;
      else if (state_q == DS_ACQ || state_q == DS_CONV) cnt_q <= bit_end ? 8'h00 : cnt_q + 8'h01;
      if (state_q != DS_CONV) bit_q <= 4'h0;
      else if (bit_end) bit_q <= bit_q + 4'h1;
    end
  end

  // sample capture and bit decisions, msb first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q   <= 16'h0000;
      sar_q    <= 16'h0000;
      result_q <= 16'h0000;
    end else begin
      if (state_q != DS_CONV && state_d == DS_CONV) begin
        held_q <= sample_value;  // hold taken on entry
        sar_q  <= 16'h0000;
      end
      if (bit_end) sar_q[4'(`ACC_MSB) - bit_q] <= held_q[4'(`ACC_MSB) - bit_q];
      if (conv_done) result_q <= acc_code({sar_q[15:1], held_q[0]}, pin_q.coding);
    end
  end

  // serial shift-out, internal clock divider and slave read tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q     <= 16'h0000;
      left_q      <= 5'h00;
      int_sclk_q  <= 1'b0;
      div_q       <= 4'h0;
      rderr_q     <= 1'b0;
      read_act_q  <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else if (pin_q.reset) begin
      shift_q     <= 16'h0000;
      left_q      <= 5'h00;
      int_sclk_q  <= 1'b0;
      div_q       <= 4'h0;
      rderr_q     <= 1'b0;
      read_act_q  <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_q.sclk;
      rderr_q     <= 1'b0;
      if (conv_done) begin
        // a fresh result replaces whatever was left unread
        shift_q    <= acc_code({sar_q[15:1], held_q[0]}, pin_q.coding);
        left_q     <= 5'(`ACC_RES_BITS);
        rderr_q    <= read_act_q && serial && ext_clk;
        read_act_q <= 1'b0;
        int_sclk_q <= 1'b0;
        div_q      <= 4'h0;
      end else if (serial && ext_clk) begin
        if (sclk_fall && left_q != 5'h00) begin
          shift_q    <= {shift_q[14:0], 1'b0};
          left_q     <= left_q - 5'h01;
          read_act_q <= (left_q != 5'h01);
        end
      end else if (serial && rd_en && state_q != DS_CONV && (left_q != 5'h00 || int_sclk_q)) begin
        div_q <= half_tick ? 4'h0 : div_q + 4'h1;
        if (half_tick) begin
          int_sclk_q <= ~int_sclk_q;
          if (int_sclk_q) begin
            shift_q <= {shift_q[14:0], 1'b0};
            left_q  <= left_q - 5'h01;
          end
        end
      end else begin
        div_q <= 4'h0;
      end
    end
  end

  // registered pin data: parallel result or serial port signals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_q <= 12'h000;
      hi_q <= 4'h0;
    end else begin
      hi_q <= rd_en ? result_q[15:12] : 4'h0;
      if (!serial) begin
        lo_q <= result_q[11:0];
      end else begin
        lo_q <= 12'h000;
        lo_q[`ACC_PIN_SERIAL_RESULT_OUT] <= shift_q[`ACC_MSB];
        lo_q[`ACC_PIN_SCLK]  <= int_sclk_q;
        lo_q[`ACC_PIN_SYNC]  <= rd_en && !ext_clk && left_q != 5'h00;
        lo_q[`ACC_PIN_RDERR] <= rderr_q;
      end
    end
  end

  // pin enables; the upper four pins never turn around
  always_comb begin
    link.dev_lo_oe = 12'h000;
    if (!serial) begin
      link.dev_lo_oe = rd_en ? 12'hfff : 12'h000;
    end else begin
      link.dev_lo_oe[`ACC_PIN_SERIAL_RESULT_OUT] = rd_en;
      link.dev_lo_oe[`ACC_PIN_SCLK]  = rd_en && !ext_clk;
      link.dev_lo_oe[`ACC_PIN_SYNC]  = !ext_clk;
      link.dev_lo_oe[`ACC_PIN_RDERR] = ext_clk;
    end
  end

  assign link.dev_lo_o  = lo_q;
  assign link.dev_hi_o  = hi_q;
  assign link.busy      = state_q[2];
  assign sample_hold    = state_q[2];
  assign low_power      = state_q[3];
  assign ref_powered    = ~pin_q.ref_off;
  assign ref_buffer_on  = ~pin_q.buf_off;
  assign last_result    = result_q;

endmodule

// ### hdl/acc_host.sv
/*
  controller end: AHB-Lite register slave, start strobe, busy watch,
  parallel or serial result read, sticky interrupts with mask.
  assumes one AHB-Lite master on hclk; link pins are resynchronised.
*/
`timescale 1ns/10ps
`include "acc_map.svh"

module acc_host import acc_pkg::*; (
  input  wire logic        hclk,      // bus clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic [31:0]      hrdata,    // read data
  output logic             hreadyout, // never stalls
  output logic             hresp,     // always okay
  output logic             irq,       // level interrupt
  acc_if.host              link       // pins to the converter
);

  acc_host_state_e state_q;         // controller state
  logic [16:0] s1_q, s2_q, s3_q, in_q; // {busy, bus} synchroniser
  logic [7:0]  ctrl_q;              // control register
  logic [15:0] result_q;            // last result read
  logic [1:0]  istat_q, imask_q;    // sticky status, mask
  logic        wr_q;                // write data phase pending
  logic [4:0]  wa_q;                // its offset
  logic [3:0]  cnt_q;               // strobe and clock timer
  logic [4:0]  got_q;               // serial bits taken
  logic        sclk_q;              // generated serial clock
  logic        busy_prev_q, sclk_prev_q, rderr_prev_q;
  logic        busy_s, busy_fall, sclk_rise, rderr_rise, start_wr, addr_ok;
  logic [1:0]  iset;

  assign busy_s     = in_q[16];
  assign busy_fall  = busy_prev_q & ~busy_s;
  assign sclk_rise  = ~sclk_prev_q & in_q[`ACC_PIN_SCLK];
  assign rderr_rise = ~rderr_prev_q & in_q[`ACC_PIN_RDERR] & ctrl_q[`ACC_CB_SERIAL];
  assign addr_ok    = hsel & htrans[1] & hready;
  assign start_wr   = wr_q && wa_q == `ACC_REG_CTRL && hwdata[`ACC_CB_START];
  assign iset       = {rderr_rise, busy_fall};

  // three-stage synchroniser for pins from the converter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 17'h00000;
      s2_q <= 17'h00000;
      s3_q <= 17'h00000;
      in_q <= 17'h00000;
    end else begin
      s1_q <= {link.busy, link.d_bus};
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (s3_q & ~(s2_q ^ s3_q)) | (in_q & (s2_q ^ s3_q));
    end
  end

  // edge history of synchronised pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_prev_q  <= 1'b0;
      sclk_prev_q  <= 1'b0;
      rderr_prev_q <= 1'b0;
    end else begin
      busy_prev_q  <= busy_s;
      sclk_prev_q  <= in_q[`ACC_PIN_SCLK];
      rderr_prev_q <= in_q[`ACC_PIN_RDERR];
    end
  end

  // bus address phase and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      wa_q   <= 5'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_q <= addr_ok & hwrite;
      wa_q <= haddr[4:0];
      if (addr_ok && !hwrite) begin
        case (haddr[4:0])
          `ACC_REG_CTRL:   hrdata <= {24'h000000, ctrl_q};
          `ACC_REG_STATUS: hrdata <= {28'h0000000, state_q};
          `ACC_REG_RESULT: hrdata <= {16'h0000, result_q};
          `ACC_REG_ISTAT:  hrdata <= {30'h00000000, istat_q};
          `ACC_REG_IMASK:  hrdata <= {30'h00000000, imask_q};
          default:         hrdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // control and mask registers; start bit never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= 8'h20;
      imask_q <= 2'h0;
    end else if (wr_q) begin
      if (wa_q == `ACC_REG_CTRL) ctrl_q <= {hwdata[7:1], 1'b0};
      if (wa_q == `ACC_REG_IMASK) imask_q <= hwdata[1:0];
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= 2'h0;
    end else begin
      istat_q <= (istat_q & ~((wr_q && wa_q == `ACC_REG_ISTAT) ? hwdata[1:0] : 2'h0)) | iset;
    end
  end

  // start, wait for busy to fall, then read the result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= HS_IDLE;
      cnt_q    <= 4'h0;
      got_q    <= 5'h00;
      sclk_q   <= 1'b0;
      result_q <= 16'h0000;
    end else if (ctrl_q[`ACC_CB_RESET]) begin
      state_q <= HS_IDLE;  // converter held in reset
      sclk_q  <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE: begin
          cnt_q <= 4'h0;
          got_q <= 5'h00;
          // a start while busy or powered down is ignored
          if (start_wr && !busy_s && !ctrl_q[`ACC_CB_PD]) state_q <= HS_START;
        end
        HS_START: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(`ACC_START_LOW - 1)) state_q <= HS_WAIT;
        end
        HS_WAIT: begin
          cnt_q <= 4'h0;
          if (busy_fall) state_q <= HS_READ;
        end
        HS_READ: begin
          if (!ctrl_q[`ACC_CB_SERIAL]) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(`ACC_READ_HOLD - 1)) begin
              result_q <= in_q[15:0];
              state_q  <= HS_IDLE;
            end
          end else begin
            if (ctrl_q[`ACC_CB_CLKSRC]) begin
              cnt_q <= (cnt_q == 4'(`ACC_SCLK_HALF - 1)) ? 4'h0 : cnt_q + 4'h1;
              // the last falling edge is still sent so the clock parks low
              if (cnt_q == 4'(`ACC_SCLK_HALF - 1) && (got_q != 5'(`ACC_RES_BITS) || sclk_q)) begin
                sclk_q <= ~sclk_q;
              end
            end
            if (sclk_rise) begin
              result_q <= {result_q[14:0], in_q[`ACC_PIN_SERIAL_RESULT_OUT]};
              got_q    <= got_q + 5'h01;
            end
            if (got_q == 5'(`ACC_RES_BITS) && !sclk_q && !in_q[`ACC_PIN_SCLK]) state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  assign link.conversion_start_n   = (state_q != HS_START);
  assign link.cs_n                 = (state_q != HS_READ);
  assign link.rd_n                 = (state_q != HS_READ);
  assign link.reset                = ctrl_q[`ACC_CB_RESET];
  assign link.power_down           = ctrl_q[`ACC_CB_PD];
  assign link.internal_ref_off     = ctrl_q[`ACC_CB_REFOFF];
  assign link.ref_buffer_off       = ctrl_q[`ACC_CB_BUFOFF];
  assign link.interface_select     = ctrl_q[`ACC_CB_SERIAL];
  assign link.output_coding_select = ctrl_q[`ACC_CB_CODING];
  assign link.clock_source_select  = ctrl_q[`ACC_CB_CLKSRC];
  assign link.host_sclk_o          = sclk_q;
  assign link.host_sclk_oe         = ctrl_q[`ACC_CB_SERIAL] & ctrl_q[`ACC_CB_CLKSRC];
  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign irq                       = |(istat_q & imask_q);

endmodule

// ### dv/acc_props.sv
/* assertions on the link between converter and controller.
   assumes both ends share hclk and hresetn; inputs are interface signals. */
`timescale 1ns/10ps
module acc_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        conversion_start_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        reset,
  input wire logic        power_down,
  input wire logic        interface_select,
  input wire logic        busy,
  input wire logic [11:0] dev_lo_o,
  input wire logic [11:0] dev_lo_oe,
  input wire logic [3:0]  dev_hi_o,
  input wire logic        host_sclk_oe
);
  logic [9:0] bcnt_q; // cycles busy has stood high
  logic [3:0] sage_q; // cycles since start strobe was low
  // busy length, cleared whenever busy is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bcnt_q <= 10'h0;
    else bcnt_q <= busy ? bcnt_q + 10'h1 : 10'h0;
  end
  // start age, saturates so an old strobe never looks fresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sage_q <= 4'hf;
    else if (!conversion_start_n) sage_q <= 4'h0;
    else if (sage_q != 4'hf) sage_q <= sage_q + 4'h1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_busy_len: assert property (disable iff (!hresetn || reset)
    $fell(busy) |-> bcnt_q inside {[799:801]}) else $error("busy length wrong");
  a_start_cause: assert property ($rose(busy) |-> sage_q <= 4'h8)
    else $error("conversion without start");
  a_hi_quiet: assert property ((!interface_select && (cs_n || rd_n))[*6]
    |-> dev_lo_oe[8:0] == 9'h0 && dev_hi_o == 4'h0) else $error("bus driven unread");
  a_rd_enable: assert property ((!interface_select && !cs_n && !rd_n)[*6]
    |-> dev_lo_oe == 12'hfff) else $error("parallel bus not enabled");
  a_reset_abort: assert property (reset[*6] |-> !busy)
    else $error("busy during reset");
  a_pd_refuse: assert property (power_down[*8] ##0 !busy |=> !busy)
    else $error("conversion in power down");
  a_start_idle: assert property ($fell(conversion_start_n) |-> !busy)
    else $error("start while busy");
  a_sclk_par: assert property (host_sclk_oe |-> interface_select && !dev_lo_oe[9])
    else $error("serial clock driven in parallel or contended");
  a_rderr_pulse: assert property (
    $rose(interface_select && dev_lo_oe[11] && dev_lo_o[11]) |=> !dev_lo_o[11])
    else $error("read error pulse too long");
endmodule

// ### dv/tb.sv
/* bench for the converter pair: an AHB-Lite master drives the controller,
   which runs the converter over the link. assumes hclk at 125 MHz. */
`timescale 1ns/10ps
`include "acc_map.svh"
module tb;
  logic        hclk = 0;               // bus clock
  logic        hresetn = 0;            // held low six cycles
  logic        hsel = 0, hwrite = 0;   // bus qualifiers
  logic [31:0] haddr = 0, hwdata = 0;  // bus address and write data
  logic [31:0] hrdata;                 // read data
  logic [1:0]  htrans = 0;             // idle at start
  logic [2:0]  hsize = 3'h2;           // words only
  logic        hreadyout, hresp, irq, sample_hold, low_power, ref_powered, ref_buffer_on;
  logic [15:0] sample_value = 0, last_result; // level to convert, latched code
  int          n_errors = 0, checks_done = 0;
  acc_if acc_if_i ();
  acc_host acc_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .link(acc_if_i));
  acc_dev acc_dev_i (.hclk, .hresetn, .link(acc_if_i), .sample_value, .sample_hold,
    .low_power, .ref_powered, .ref_buffer_on, .last_result);
  acc_props acc_props_i (.hclk, .hresetn, .conversion_start_n(acc_if_i.conversion_start_n),
    .cs_n(acc_if_i.cs_n), .rd_n(acc_if_i.rd_n), .reset(acc_if_i.reset),
    .power_down(acc_if_i.power_down), .interface_select(acc_if_i.interface_select),
    .busy(acc_if_i.busy), .dev_lo_o(acc_if_i.dev_lo_o), .dev_lo_oe(acc_if_i.dev_lo_oe),
    .dev_hi_o(acc_if_i.dev_hi_o), .host_sclk_oe(acc_if_i.host_sclk_oe));
  always #4 hclk = ~hclk;
  // one bus transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one conversion in mode m, read back, interrupt masked and cleared
  task automatic convert(input logic [31:0] m, input logic [15:0] s);
    logic [31:0] r;
    int          n;
    sample_value <= s;
    repeat (200) @(posedge hclk); // let acquisition end with start high
    ahb(1, `ACC_REG_CTRL, m, r);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin @(posedge hclk); n++; end
    chk(32'(irq), 32'h1);
    r = 0; n = 0;
    while (r[3:0] !== 4'h1 && n < 400) begin ahb(0, `ACC_REG_STATUS, 0, r); n++; end
    chk(r, 32'h1);
    ahb(0, `ACC_REG_RESULT, 0, r);
    chk(r, 32'(m[5] ? s : s ^ 16'h8000));
    chk(32'(last_result), 32'(m[5] ? s : s ^ 16'h8000));
    ahb(1, `ACC_REG_IMASK, 0, r);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    ahb(1, `ACC_REG_IMASK, 1, r);
    ahb(1, `ACC_REG_ISTAT, 1, r);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
  endtask
  // static reference pins follow their controls
  task automatic s_refs();
    logic [31:0] r;
    ahb(1, `ACC_REG_CTRL, 32'h2c, r);
    repeat (8) @(posedge hclk);
    chk(32'({ref_powered, ref_buffer_on}), 32'h0);
    ahb(1, `ACC_REG_CTRL, 32'h20, r);
    repeat (8) @(posedge hclk);
    chk(32'({ref_powered, ref_buffer_on}), 32'h3);
  endtask
  // power down: sleep, no conversion, wake on release
  task automatic s_pd();
    logic [31:0] r;
    ahb(1, `ACC_REG_CTRL, 32'h22, r);
    repeat (250) @(posedge hclk);
    chk(32'(low_power), 32'h1);
    ahb(1, `ACC_REG_CTRL, 32'h23, r);
    repeat (1000) @(posedge hclk);
    chk(32'(acc_if_i.busy), 32'h0);
    ahb(1, `ACC_REG_CTRL, 32'h20, r);
    repeat (8) @(posedge hclk);
    chk(32'(low_power), 32'h0);
  endtask
  // reset in mid-conversion aborts it
  task automatic s_abort();
    logic [31:0] r;
    repeat (200) @(posedge hclk);
    ahb(1, `ACC_REG_CTRL, 32'h21, r);
    repeat (100) @(posedge hclk);
    chk(32'({acc_if_i.busy, sample_hold}), 32'h3);
    ahb(1, `ACC_REG_CTRL, 32'ha0, r);
    repeat (10) @(posedge hclk);
    chk(32'(acc_if_i.busy), 32'h0);
    ahb(1, `ACC_REG_CTRL, 32'h20, r);
    ahb(0, `ACC_REG_STATUS, 0, r);
    chk(r, 32'h1);
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence: parallel both codings, serial both clock sources
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    ahb(0, `ACC_REG_CTRL, 0, r);
    chk(r, 32'h20);
    chk(32'({hresp, hreadyout}), 32'h1);
    chk(32'({ref_powered, ref_buffer_on}), 32'h3);
    ahb(0, 5'h1c, 0, r);
    chk(r, 32'h0);
    ahb(1, `ACC_REG_IMASK, 1, r);
    convert(32'h21, 16'h1234);
    convert(32'h01, 16'hfffe);
    convert(32'h31, 16'ha5c3);
    convert(32'h71, 16'h8001);
    s_refs();
    s_pd();
    s_abort();
    test_done();
  end
  // watchdog far beyond the expected run
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    test_done();
  end
endmodule
